// *** design/pcm_cycle_div.sv ***
`timescale 1ns/1ps

module pcm_cycle_div
  import pcm_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire pcm_pkg::pcm_div_type i_code,
  output logic o_ce
);

  logic [9:0] cnt_q;

  // clocks per cycle
  // A faster code taking over mid-count wraps at once via the compare.
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      cnt_q <= 10'h000;
      o_ce <= 1'b0;
    end
    else if (cnt_q >= pcm_last_count(i_code))
    begin
      cnt_q <= 10'h000;
      o_ce <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q + 10'h001;
      o_ce <= 1'b0;
    end
  end

endmodule : pcm_cycle_div

// *** design/pcm_rst_gen.sv ***
`timescale 1ns/1ps

module pcm_rst_gen
  import pcm_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ext_pin,
  input wire logic i_por,
  input wire logic i_wdt_fire,
  output logic o_rst
);

  logic [3:0] hi_cnt_q;
  logic [3:0] hold_q;
  logic ext_ok;

  assign ext_ok = (hi_cnt_q == `PCM_EXT_RST_CLKS);

  always_ff @(posedge i_clk)
  begin
    if (i_rst || !i_ext_pin)
      hi_cnt_q <= 4'h0;
    else if (!ext_ok)
      hi_cnt_q <= hi_cnt_q + 4'h1;
  end

  // Reset is kept eight master clocks past the end of every source.
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      hold_q <= 4'h0;
    else if (ext_ok || i_por || i_wdt_fire)
      hold_q <= `PCM_RST_HOLD_CLKS;
    else if (hold_q != 4'h0)
      hold_q <= hold_q - 4'h1;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_rst <= 1'b0;
    else
      o_rst <= ext_ok || i_por || i_wdt_fire || (hold_q != 4'h0);
  end

  AST_EXT_RST: assert property (@(posedge i_clk) disable iff (i_rst)
    i_ext_pin [*8] |=> ext_ok ##1 o_rst)
    else $error("External reset held eight clocks was not recognised.");

endmodule : pcm_rst_gen

// *** design/pcm_top.sv ***
// Behaviour
// - Writing one to the idle bit enters idle after that write.
// - Idle stops only the CPU clock; peripherals keep running, CPU state held.
// - In idle, address strobe and fetch strobe are high; port pins hold.
// - Any enabled interrupt in idle clears the idle bit and wakes the CPU.
// - External reset needs eight clocks high, then resets all control registers at once, but not the cycle counter.
// - A reset ending idle skips the instruction after the idle write.
// - Watchdog runs in idle; time-out wakes, reset follows 512 clocks later.
// - Divider field bits 7:6: 01 is 4, 10 is 64, 11 is 1024.
// - Economy slows peripherals too; idle runs them at clock over four.
// - A new divider takes effect one machine cycle after the write.
// - Bit 3 of the flag register selects crystal or RC oscillator.
// - Amplifier off only while on RC; clear it before choosing crystal.
// - Bit 2 shows the source in use; changes land one cycle later.
// - Crystal ready flag sets after warm-up; crystal refused until then.
// - With fast return on, external interrupt acknowledges or serial traffic force divide-by-4.
// - Start-bit edge with receive on, or transmit buffer write, triggers it.
// - Fast return ignores serial interrupt flags; economy may be re-entered.
// - Divider writes ignored while fast return is on and serial is busy.
// - Watchdog, power-on and external resets force divide-by-4.
`timescale 1ns/1ps

module pcm_top
  import pcm_pkg::*;
(
  input wire logic I_MCLK,
  input wire logic I_SYS_RST,
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [7:0] I_WB_ADR,
  input wire logic [31:0] I_WB_DAT,
  input wire logic [3:0] I_WB_SEL,
  output logic [31:0] O_WB_DAT,
  output logic O_WB_ACK,
  input wire logic I_EXT_RST,
  input wire logic I_POR,
  input wire logic I_INT_WAKE,
  input wire logic I_EXT_INT_ACK,
  input wire logic I_RX_START_FALL,
  input wire logic I_RX_ENABLE,
  input wire logic I_TX_BUF_WRITE,
  input wire logic I_SERIAL_BUSY,
  input wire logic I_WDT_TIMEOUT,
  input wire logic I_XTAL_STABLE,
  input wire logic I_ALE_CORE,
  input wire logic I_PROGRAM_FETCH_STROBE_CORE,
  output logic O_CPU_CLK_EN,
  output logic O_PERIPH_CLK_EN,
  output logic O_IDLE,
  output logic O_CORE_RST,
  output logic O_PORT_HOLD,
  output logic O_ALE,
  output logic O_PROGRAM_FETCH_STROBE,
  output logic O_OSC_SEL_XTAL,
  output logic O_XTAL_AMP_EN,
  output logic O_WDT_INT
);

  import pcm_pkg::*;

  // ----------------------------------------------------------------
  // Internal state
  // ----------------------------------------------------------------
  logic rst_lvl;
  logic rst_int;
  logic div_ce;
  logic idle_q;
  pcm_div_type div_q;
  pcm_div_type div_pend_q;
  pcm_div_type div_wr;
  pcm_div_type per_code;
  logic pend_v_q;
  logic fre_q;
  logic amp_off_q;
  logic osc_req_q;
  logic osc_cur_q;
  logic xrdy_q;
  logic wd_ien_q;
  logic wd_ren_q;
  logic wd_flag_q;
  logic [9:0] wd_cnt_q;
  logic wdt_fire;
  logic wake;
  logic swb_ev;
  logic acc;
  logic wr;
  logic div_wr_ok;

  assign rst_int = I_SYS_RST || rst_lvl;
  assign acc = I_WB_CYC && I_WB_STB && !O_WB_ACK;
  // A write lands at the edge at which the master sees the acknowledge.
  assign wr = I_WB_CYC && I_WB_STB && O_WB_ACK && I_WB_WE && I_WB_SEL[0];
  assign div_wr = pcm_div_type'(I_WB_DAT[`PCM_DIV_HI:`PCM_DIV_LO]);
  assign wake = I_INT_WAKE || (wd_flag_q && wd_ien_q);
  assign per_code = idle_q ? PCM_DIV_4 : div_q;

  // ----------------------------------------------------------------
  // Reset and cycle rate
  // ----------------------------------------------------------------
  pcm_rst_gen u_rst (
    .i_clk(I_MCLK),
    .i_rst(I_SYS_RST),
    .i_ext_pin(I_EXT_RST),
    .i_por(I_POR),
    .i_wdt_fire(wdt_fire),
    .o_rst(rst_lvl)
  );

  pcm_cycle_div u_div (
    .i_clk(I_MCLK),
    .i_rst(I_SYS_RST),
    .i_code(per_code),
    .o_ce(div_ce)
  );

  // ----------------------------------------------------------------
  // Wishbone slave, one wait state
  // ----------------------------------------------------------------
  always_ff @(posedge I_MCLK)
  begin
    if (I_SYS_RST)
      O_WB_ACK <= 1'b0;
    else
      O_WB_ACK <= acc;
  end

  // Unmapped offsets are acknowledged and read as zero.
  always_ff @(posedge I_MCLK)
  begin
    if (I_SYS_RST)
      O_WB_DAT <= 32'h00000000;
    else if (acc)
    begin
      O_WB_DAT <= 32'h00000000;
      unique case (I_WB_ADR)
        `PCM_OFF_PWR_CTRL: O_WB_DAT[`PCM_BIT_IDLE] <= idle_q;
        `PCM_OFF_PWR_MODE:
        begin
          O_WB_DAT[`PCM_DIV_HI:`PCM_DIV_LO] <= div_q;
          O_WB_DAT[`PCM_BIT_FRE] <= fre_q;
          O_WB_DAT[`PCM_BIT_XOFF] <= amp_off_q;
        end
        `PCM_OFF_EXT_FLAG:
        begin
          O_WB_DAT[`PCM_BIT_OSC_SEL] <= osc_req_q;
          O_WB_DAT[`PCM_BIT_OSC_IND] <= !osc_cur_q;
        end
        `PCM_OFF_STATUS: O_WB_DAT[`PCM_BIT_XRDY] <= xrdy_q;
        `PCM_OFF_WDT_CTRL:
        begin
          O_WB_DAT[`PCM_BIT_WD_IEN] <= wd_ien_q;
          O_WB_DAT[`PCM_BIT_WD_REN] <= wd_ren_q;
          O_WB_DAT[`PCM_BIT_WD_FLAG] <= wd_flag_q;
        end
        default: O_WB_DAT <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Idle control
  // ----------------------------------------------------------------
  // wake clears idle
  always_ff @(posedge I_MCLK)
  begin
    if (rst_int)
      idle_q <= 1'b0;
    else if (wake)
      idle_q <= 1'b0;
    else if (wr && (I_WB_ADR == `PCM_OFF_PWR_CTRL) && I_WB_DAT[`PCM_BIT_IDLE])
      idle_q <= 1'b1;
  end

  // ----------------------------------------------------------------
  // Clock divider with fast return
  // ----------------------------------------------------------------
  // serial start and external interrupt triggers
  assign swb_ev = fre_q && (I_EXT_INT_ACK || (I_RX_START_FALL && I_RX_ENABLE)
                  || I_TX_BUF_WRITE);
  assign div_wr_ok = wr && (I_WB_ADR == `PCM_OFF_PWR_MODE) && (div_wr != PCM_DIV_RSV)
                     && !(fre_q && I_SERIAL_BUSY);

  always_ff @(posedge I_MCLK)
  begin
    if (rst_int)
      fre_q <= 1'b0;
    else if (wr && (I_WB_ADR == `PCM_OFF_PWR_MODE))
      fre_q <= I_WB_DAT[`PCM_BIT_FRE];
  end

  always_ff @(posedge I_MCLK)
  begin
    if (rst_int)
    begin
      div_q <= PCM_DIV_4;
      div_pend_q <= PCM_DIV_4;
      pend_v_q <= 1'b0;
    end
    else if (swb_ev)
    begin
      div_q <= PCM_DIV_4;
      pend_v_q <= 1'b0;
    end
    else if (div_wr_ok)
    begin
      div_pend_q <= div_wr;
      pend_v_q <= 1'b1;
    end
    else if (pend_v_q && div_ce)
    begin
      div_q <= div_pend_q;
      pend_v_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Oscillator source
  // ----------------------------------------------------------------
  // amplifier off only on RC
  always_ff @(posedge I_MCLK)
  begin
    if (rst_int)
      amp_off_q <= 1'b0;
    else if (wr && (I_WB_ADR == `PCM_OFF_PWR_MODE) && !osc_cur_q && !osc_req_q)
      amp_off_q <= I_WB_DAT[`PCM_BIT_XOFF];
  end

  always_ff @(posedge I_MCLK)
  begin
    if (rst_int || amp_off_q)
      xrdy_q <= 1'b0;
    else if (I_XTAL_STABLE)
      xrdy_q <= 1'b1;
  end

  // source select, crystal refused when not ready
  always_ff @(posedge I_MCLK)
  begin
    if (rst_int)
      osc_req_q <= 1'b0;
    else if (wr && (I_WB_ADR == `PCM_OFF_EXT_FLAG))
      osc_req_q <= I_WB_DAT[`PCM_BIT_OSC_SEL] && xrdy_q;
  end

  always_ff @(posedge I_MCLK)
  begin
    if (rst_int)
      osc_cur_q <= 1'b0;
    else if (div_ce)
      osc_cur_q <= osc_req_q;
  end

  // ----------------------------------------------------------------
  // Watchdog time-out and delayed reset
  // ----------------------------------------------------------------
  always_ff @(posedge I_MCLK)
  begin
    if (rst_int)
    begin
      wd_ien_q <= 1'b0;
      wd_ren_q <= 1'b0;
    end
    else if (wr && (I_WB_ADR == `PCM_OFF_WDT_CTRL))
    begin
      wd_ien_q <= I_WB_DAT[`PCM_BIT_WD_IEN];
      wd_ren_q <= I_WB_DAT[`PCM_BIT_WD_REN];
    end
  end

  // A time-out in the clearing cycle survives: the set wins.
  always_ff @(posedge I_MCLK)
  begin
    if (rst_int)
      wd_flag_q <= 1'b0;
    else if (I_WDT_TIMEOUT)
      wd_flag_q <= 1'b1;
    else if (wr && (I_WB_ADR == `PCM_OFF_WDT_CTRL) && I_WB_DAT[`PCM_BIT_WD_CLR])
      wd_flag_q <= 1'b0;
  end

  always_ff @(posedge I_MCLK)
  begin
    if (rst_int || !wd_flag_q || !wd_ren_q)
      wd_cnt_q <= 10'h000;
    else if (!wdt_fire)
      wd_cnt_q <= wd_cnt_q + 10'h001;
  end

  assign wdt_fire = (wd_cnt_q == (`PCM_WDT_RST_CLKS - 10'h001));

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge I_MCLK)
  begin
    if (I_SYS_RST)
    begin
      O_CPU_CLK_EN <= 1'b0;
      O_PERIPH_CLK_EN <= 1'b0;
      O_IDLE <= 1'b0;
      O_CORE_RST <= 1'b1;
      O_PORT_HOLD <= 1'b0;
      O_ALE <= 1'b1;
      O_PROGRAM_FETCH_STROBE <= 1'b1;
      O_OSC_SEL_XTAL <= 1'b0;
      O_XTAL_AMP_EN <= 1'b1;
      O_WDT_INT <= 1'b0;
    end
    else
    begin
      O_CPU_CLK_EN <= div_ce && !idle_q && !rst_int;
      O_PERIPH_CLK_EN <= div_ce;
      O_IDLE <= idle_q;
      O_CORE_RST <= rst_int;
      O_PORT_HOLD <= idle_q;
      O_ALE <= idle_q || I_ALE_CORE;
      O_PROGRAM_FETCH_STROBE <= idle_q || I_PROGRAM_FETCH_STROBE_CORE;
      O_OSC_SEL_XTAL <= osc_cur_q;
      O_XTAL_AMP_EN <= !amp_off_q;
      O_WDT_INT <= wd_flag_q && wd_ien_q;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (I_SYS_RST);

  sequence s_idle_tick;
    O_PERIPH_CLK_EN && idle_q && !rst_int ##1 (idle_q && !rst_int) [*3];
  endsequence

  sequence s_div_write;
    div_wr_ok && !swb_ev && !rst_int;
  endsequence

  AST_IDLE_CPU_STOP: assert property (idle_q |=> !O_CPU_CLK_EN)
    else $error("CPU clock ran during idle.");
  AST_IDLE_PERIPH: assert property (s_idle_tick |=> O_PERIPH_CLK_EN)
    else $error("Peripheral rate in idle is not clock over four.");
  AST_IDLE_PINS: assert property (idle_q |=> O_ALE && O_PROGRAM_FETCH_STROBE
    && O_PORT_HOLD)
    else $error("Idle pin levels wrong.");
  AST_WAKE: assert property (idle_q && wake |=> !idle_q ##1 !O_IDLE)
    else $error("Enabled interrupt did not end idle.");
  AST_RST_IDLE: assert property (rst_int |=> !idle_q ##0 O_CORE_RST)
    else $error("Reset did not end idle and reset the core.");
  AST_WDT_DELAY: assert property (wdt_fire && !rst_int |-> wd_flag_q && wd_ren_q
    && $past(wd_cnt_q) == 10'h1FE)
    else $error("Watchdog reset not 512 clocks after time-out.");
  AST_DIV_LEGAL: assert property (div_q != PCM_DIV_RSV)
    else $error("Divider holds the reserved code.");
  AST_DIV_DELAY: assert property (s_div_write |=> $stable(div_q) ##0 pend_v_q)
    else $error("Divider changed without waiting a cycle.");
  AST_SWB: assert property (swb_ev && !rst_int |=> div_q == PCM_DIV_4 && !pend_v_q)
    else $error("Fast return did not restore divide-by-4.");
  AST_DIV_LOCK: assert property (fre_q && I_SERIAL_BUSY && !pend_v_q |=> !pend_v_q)
    else $error("Divider write accepted during serial traffic.");
  AST_RST_DIV: assert property (rst_int |=> div_q == PCM_DIV_4)
    else $error("Reset left a slow divider.");
  AST_XTAL_REFUSE: assert property (!xrdy_q && !osc_req_q |=> !osc_req_q)
    else $error("Crystal selected before warm-up.");
  AST_OSC_IND: assert property ($changed(osc_cur_q) && !$past(rst_int) |->
    $past(div_ce))
    else $error("Source changed off a cycle boundary.");

endmodule : pcm_top

// *** include/pcm_pkg.sv ***
`include "pcm_regs.svh"

package pcm_pkg;

  typedef enum logic [1:0] {
    PCM_DIV_RSV = 2'b00,
    PCM_DIV_4 = 2'b01,
    PCM_DIV_64 = 2'b10,
    PCM_DIV_1024 = 2'b11
  } pcm_div_type;

  function automatic logic [9:0] pcm_last_count(input pcm_div_type code);
    unique case (code)
      PCM_DIV_64: pcm_last_count = `PCM_LAST_DIV64;
      PCM_DIV_1024: pcm_last_count = `PCM_LAST_DIV1024;
      default: pcm_last_count = `PCM_LAST_DIV4;
    endcase
  endfunction : pcm_last_count

endpackage : pcm_pkg

// *** include/pcm_regs.svh ***
`ifndef PCM_REGS_SVH
`define PCM_REGS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define PCM_OFF_PWR_CTRL 8'h00
`define PCM_OFF_PWR_MODE 8'h04
`define PCM_OFF_EXT_FLAG 8'h08
`define PCM_OFF_STATUS 8'h0C
`define PCM_OFF_WDT_CTRL 8'h10

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PCM_BIT_IDLE 0
`define PCM_DIV_HI 7
`define PCM_DIV_LO 6
`define PCM_BIT_FRE 5
`define PCM_BIT_XOFF 3
`define PCM_BIT_OSC_SEL 3
`define PCM_BIT_OSC_IND 2
`define PCM_BIT_XRDY 4
`define PCM_BIT_WD_IEN 0
`define PCM_BIT_WD_REN 1
`define PCM_BIT_WD_CLR 2
`define PCM_BIT_WD_FLAG 3

// ----------------------------------------------------------------
// Timing counts in master clocks
// ----------------------------------------------------------------
`define PCM_EXT_RST_CLKS 4'd8
`define PCM_RST_HOLD_CLKS 4'd8
`define PCM_WDT_RST_CLKS 10'd512
`define PCM_LAST_DIV4 10'd3
`define PCM_LAST_DIV64 10'd63
`define PCM_LAST_DIV1024 10'd1023

`endif

// *** sim/tb_top.sv ***
`timescale 1ns/1ps
`include "pcm_regs.svh"

module tb_top;
  import pcm_pkg::*;

  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  localparam logic [7:0] a_ctrl = `PCM_OFF_PWR_CTRL;
  localparam logic [7:0] a_mode = `PCM_OFF_PWR_MODE;
  localparam logic [7:0] a_ext = `PCM_OFF_EXT_FLAG;
  localparam logic [7:0] a_stat = `PCM_OFF_STATUS;
  localparam logic [7:0] a_wdt = `PCM_OFF_WDT_CTRL;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [3:0] sel = 4'hF;
  logic [31:0] rdat;
  logic ack;
  logic ext_rst = 1'b0;
  logic por = 1'b0;
  logic rx_en = 1'b0;
  logic ser_busy = 1'b0;
  logic xtal_ok = 1'b0;
  logic ale_c = 1'b0;
  logic fetch_c = 1'b0;
  // Pulse inputs: 0 tx write, 1 rx start, 2 ext int ack, 3 wdt time-out, 4 wake.
  logic [4:0] pv = 5'h00;
  logic cpu_ce, per_ce, idle, core_rst, hold, ale, fetch_o, osc_x, amp, wdt_int;
  logic [31:0] rd;
  int bad_count = 0;
  int samples_checked = 0;
  int p;
  int n;

  always #4 mclk = ~mclk;

  pcm_top u_dut (
    .I_MCLK(mclk), .I_SYS_RST(rst), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
    .I_WB_ADR(adr), .I_WB_DAT(wdat), .I_WB_SEL(sel), .O_WB_DAT(rdat), .O_WB_ACK(ack),
    .I_EXT_RST(ext_rst), .I_POR(por), .I_INT_WAKE(pv[4]), .I_EXT_INT_ACK(pv[2]),
    .I_RX_START_FALL(pv[1]), .I_RX_ENABLE(rx_en), .I_TX_BUF_WRITE(pv[0]),
    .I_SERIAL_BUSY(ser_busy), .I_WDT_TIMEOUT(pv[3]), .I_XTAL_STABLE(xtal_ok),
    .I_ALE_CORE(ale_c), .I_PROGRAM_FETCH_STROBE_CORE(fetch_c), .O_CPU_CLK_EN(cpu_ce),
    .O_PERIPH_CLK_EN(per_ce), .O_IDLE(idle), .O_CORE_RST(core_rst), .O_PORT_HOLD(hold),
    .O_ALE(ale), .O_PROGRAM_FETCH_STROBE(fetch_o), .O_OSC_SEL_XTAL(osc_x),
    .O_XTAL_AMP_EN(amp), .O_WDT_INT(wdt_int)
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge mclk);
    while (ack !== 1'b1 && k < 20)
    begin
      @(posedge mclk);
      k++;
    end
    if (k == 20)
      check("wb_ack", 32'h0, 32'h1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    check(what, rd & m, e);
  endtask : rdchk

  task automatic tick(input int c);
    repeat (c) @(posedge mclk);
  endtask : tick

  task automatic pulse(input int i);
    @(posedge mclk);
    pv[i] <= 1'b1;
    @(posedge mclk);
    pv[i] <= 1'b0;
  endtask : pulse

  // The first interval after a rate change may be short, so the third one is measured.
  task automatic period(input bit per, output int q);
    int c;
    q = 0;
    for (int k = 0; k < 3; k++)
    begin
      c = 0;
      @(posedge mclk);
      while (((per ? per_ce : cpu_ce) !== 1'b1) && c < 3000)
      begin
        @(posedge mclk);
        c++;
      end
      q = c + 1;
    end
  endtask : period

  task automatic tally_and_finish;
    if (bad_count == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    #(8 * 40000);
    bad_count++;
    tally_and_finish();
  end

  initial
  begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rdchk("div_rst", a_mode, 32'hE8, 32'h40);
    rdchk("src_rst", a_ext, 32'h0C, 32'h04);
    rdchk("unmapped", 8'h20, 32'hFFFFFFFF, 32'h0);
    period(0, p);
    check("rate4", p, 4);
    wb(1'b1, a_mode, 32'h00);
    tick(8);
    rdchk("div_rsv", a_mode, 32'hC0, 32'h40);
    for (int i = 0; i < 2; i++)
    begin
      wb(1'b1, a_mode, i ? 32'hC0 : 32'h80);
      period(0, p);
      check("cpu_rate", p, i ? 1024 : 64);
      period(1, p);
      check("per_rate", p, i ? 1024 : 64);
      wb(1'b1, a_mode, 32'h40);
      tick(1030);
    end
    wb(1'b1, a_mode, 32'h80);
    wb(1'b1, a_ctrl, 32'h01);
    tick(70);
    check("idle_pins", {28'h0, idle, hold, ale, fetch_o}, 32'hF);
    period(1, p);
    check("idle_per", p, 4);
    n = 0;
    repeat (200)
    begin
      @(posedge mclk);
      if (cpu_ce !== 1'b0)
        n++;
    end
    check("idle_cpu", n, 0);
    pulse(4);
    tick(2);
    check("wake", {idle, hold, ale, fetch_o}, 4'h0);
    rdchk("idle_bit", a_ctrl, 32'h01, 32'h0);
    rx_en <= 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      wb(1'b1, a_mode, 32'hA0);
      tick(8);
      rdchk("eco", a_mode, 32'hE0, 32'hA0);
      pulse(i);
      tick(2);
      rdchk("fast_ret", a_mode, 32'hE0, 32'h60);
    end
    rx_en <= 1'b0;
    wb(1'b1, a_mode, 32'hA0);
    tick(8);
    pulse(1);
    tick(2);
    rdchk("rx_off", a_mode, 32'hE0, 32'hA0);
    wb(1'b1, a_mode, 32'h60);
    tick(70);
    ser_busy <= 1'b1;
    wb(1'b1, a_mode, 32'hA0);
    tick(8);
    rdchk("busy", a_mode, 32'hE0, 32'h60);
    ser_busy <= 1'b0;
    wb(1'b1, a_ext, 32'h08);
    tick(8);
    rdchk("xtal_ref", a_ext, 32'h0C, 32'h04);
    check("xtal_pin0", osc_x, 1'b0);
    wb(1'b1, a_mode, 32'h48);
    tick(4);
    check("amp_off", amp, 1'b0);
    xtal_ok <= 1'b1;
    tick(4);
    rdchk("xrdy_off", a_stat, 32'h10, 32'h0);
    wb(1'b1, a_mode, 32'h40);
    tick(4);
    rdchk("xrdy", a_stat, 32'h10, 32'h10);
    wb(1'b1, a_ext, 32'h08);
    tick(8);
    rdchk("xtal_sel", a_ext, 32'h0C, 32'h08);
    check("xtal_pin1", osc_x, 1'b1);
    wb(1'b1, a_ctrl, 32'h01);
    wb(1'b1, a_wdt, 32'h01);
    pulse(3);
    tick(3);
    check("wdt_wake", {wdt_int, idle}, 2'b10);
    wb(1'b1, a_wdt, 32'h05);
    tick(2);
    check("wdt_clr", wdt_int, 1'b0);
    wb(1'b1, a_mode, 32'h80);
    wb(1'b1, a_wdt, 32'h02);
    pulse(3);
    n = 0;
    while (core_rst !== 1'b1 && n < 600)
    begin
      @(posedge mclk);
      n++;
    end
    check("wdt_rst", n >= 510 && n <= 516, 1'b1);
    n = 0;
    while (core_rst !== 1'b0 && n < 100)
    begin
      @(posedge mclk);
      n++;
    end
    rdchk("wdt_div", a_mode, 32'hC0, 32'h40);
    wb(1'b1, a_mode, 32'h80);
    wb(1'b1, a_ctrl, 32'h01);
    ext_rst <= 1'b1;
    tick(7);
    ext_rst <= 1'b0;
    tick(12);
    check("rst7", {core_rst, idle}, 2'b01);
    ext_rst <= 1'b1;
    tick(12);
    check("rst8", {core_rst, idle}, 2'b10);
    ext_rst <= 1'b0;
    n = 0;
    while (core_rst !== 1'b0 && n < 100)
    begin
      @(posedge mclk);
      n++;
    end
    rdchk("ext_div", a_mode, 32'hC0, 32'h40);
    period(0, p);
    check("ext_rate", p, 4);
    por <= 1'b1;
    tick(3);
    check("por_rst", core_rst, 1'b1);
    por <= 1'b0;
    tick(30);
    tally_and_finish();
  end

endmodule : tb_top
